// ### diag_pkg.sv
// Package with register map, field layout, reset values and pattern timing for the diag block.
package diag_pkg;
    // I/O port addresses of the two control registers.
    localparam logic [15:0] lamp_reg_addr = 16'h0210;
    localparam logic [15:0] sounder_reg_addr = 16'h0211;
    // Field positions inside each 8-bit register.
    localparam int enable_bit = 0;
    localparam int sel_lo_bit = 1;
    localparam int sel_hi_bit = 2;
    localparam int field_width = 3;
    // Reset values chosen as all off.
    localparam logic [7:0] lamp_reset = 8'h00;
    localparam logic [7:0] sounder_reset = 8'h00;
    // Prescaler: one tick every 1 ms at 50 MHz.
    localparam int clock_mhz = 50;
    localparam int tick_us = 1000;
    localparam int tick_cycles = tick_us * clock_mhz;
    // Pattern periods and on times in ticks (milliseconds).
    localparam int fast_period_ms = 200;
    localparam int fast_on_ms = 100;
    localparam int normal_period_ms = 1000;
    localparam int normal_on_ms = 500;
    localparam int short_period_ms = 1000;
    localparam int short_on_ms = 100;
    localparam int long_period_ms = 2000;
    localparam int long_on_ms = 1500;

    // Two-bit pattern selection, shared by lamp and sounder.
    typedef enum logic [1:0] {
        pat_steady,
        pat_fast,
        pat_normal,
        pat_short
    } pattern_e;

    // One control register split into fields.
    typedef struct packed {
        logic [4:0] unused;
        pattern_e pattern;
        logic enable;
    } control_s;
endpackage : diag_pkg

// ### pattern_gen.sv
// Pattern generator turning an enable and a two-bit pattern into an on/off output.
`timescale 1ns/1ps
module pattern_gen #(
    parameter int period_a = diag_pkg::fast_period_ms,
    parameter int on_a = diag_pkg::fast_on_ms,
    parameter int period_b = diag_pkg::normal_period_ms,
    parameter int on_b = diag_pkg::normal_on_ms,
    parameter int period_c = diag_pkg::short_period_ms,
    parameter int on_c = diag_pkg::short_on_ms
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tick,
    input wire diag_pkg::control_s ctrl,
    output logic out
);
    // Elaboration guard: each on time must leave some off time, and the phase is 16 bits.
    if (on_a < 1 || on_a >= period_a || on_b < 1 || on_b >= period_b ||
        on_c < 1 || on_c >= period_c || period_c > 65535 || period_b > 65535 ||
        period_a > 65535) begin : bad_timing
        $error("pattern_gen: on time must be 1..period-1, period below 65536");
    end

    logic [15:0] phase;
    diag_pkg::control_s last_ctrl;
    logic next_out;

    // Selected period and on time for the current pattern.
    wire [15:0] period_sel = (ctrl.pattern == diag_pkg::pat_fast) ? 16'(period_a) :
                             (ctrl.pattern == diag_pkg::pat_normal) ? 16'(period_b) :
                             16'(period_c);
    wire [15:0] on_sel = (ctrl.pattern == diag_pkg::pat_fast) ? 16'(on_a) :
                         (ctrl.pattern == diag_pkg::pat_normal) ? 16'(on_b) : 16'(on_c);
    // Any change of enable or pattern restarts the timer, so a new pattern starts clean.
    wire restart = (ctrl.enable != last_ctrl.enable) || (ctrl.pattern != last_ctrl.pattern);
    wire wrap = tick && (phase == period_sel - 16'h0001);

    // Output decode: disabled is off, steady is on, others follow the phase.
    always_comb begin
        case (ctrl.pattern)
            diag_pkg::pat_steady: next_out = ctrl.enable;
            diag_pkg::pat_fast,
            diag_pkg::pat_normal,
            diag_pkg::pat_short: next_out = ctrl.enable && !restart && (phase < on_sel);
            default: next_out = 1'b0;
        endcase
    end

    // Phase counter advances once per prescaler tick.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase <= 16'h0000;
            last_ctrl <= '0;
            out <= 1'b0;
        end else begin
            last_ctrl <= ctrl;
            out <= next_out;
            if (restart || wrap) begin
                phase <= 16'h0000;
            end else if (tick) begin
                phase <= phase + 16'h0001;
            end
        end
    end

    a_disabled_dark : assert property (@(posedge clock) disable iff (!resetn)
        !ctrl.enable |=> !out) else $error("output active while disabled");
    a_steady_lit : assert property (@(posedge clock) disable iff (!resetn)
        ctrl.enable && ctrl.pattern == diag_pkg::pat_steady |=> out)
        else $error("steady pattern not on");
    a_restart_phase : assert property (@(posedge clock) disable iff (!resetn)
        restart |=> phase == 16'h0000) else $error("timer not restarted");
    a_restart_dark : assert property (@(posedge clock) disable iff (!resetn)
        restart && ctrl.pattern != diag_pkg::pat_steady |=> !out)
        else $error("blink did not restart from a dark cycle");
    a_phase_range : assert property (@(posedge clock) disable iff (!resetn)
        !restart |-> phase < period_sel) else $error("phase beyond its period");
    c_blink_on : cover property (@(posedge clock) disable iff (!resetn)
        ctrl.enable && ctrl.pattern != diag_pkg::pat_steady && out);
    c_wrap : cover property (@(posedge clock) disable iff (!resetn) wrap && ctrl.enable);
endmodule : pattern_gen

// ### diag_lamp_sounder_control.sv
// Diagnostic lamp and sounder control registers on the I/O port bus.
`timescale 1ns/1ps
// Host software reaches two byte-wide ports on the system I/O bus, one for the
// lamp and one for the sounder. Each port keeps three bits: the enable in bit 0
// and a two-bit pattern code in bits 2 and 1. The upper five bits are dropped on
// a write and read back as zero, so software that sets them by mistake finds out.
// Reads and writes both take effect at the clock edge that sees the strobe, and
// the answer (read data and hit) stands for exactly the following cycle.
// A write and a read may follow each other back to back on any port.
// The blink and beep timing runs from one shared prescaler that ticks once per
// millisecond at the default setting. Each output owns a small pattern generator
// whose phase restarts whenever its register changes, so a new pattern always
// begins with its on time. The prescaler itself is not restarted; that saves a
// second counter, at the price of a first tick that may come up to one prescale
// period early.
// Both outputs are registered once more after the generators, so they come
// straight from flip-flops and trail the register write by two cycles, three when a blink starts.
// Reset clears both registers, so lamp and sounder start dark and silent.
module diag_lamp_sounder_control #(
    parameter int prescale = diag_pkg::tick_cycles
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [15:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    output logic lamp,
    output logic sounder
);
    // Elaboration guard: with a prescale of one the tick would never fall, and the
    // counter below is only twenty-four bits wide.
    if (prescale < 2 || prescale > 16777215) begin : bad_prescale
        $error("diag_lamp_sounder_control: prescale must be 2..2^24-1");
    end

    diag_pkg::control_s lamp_ctrl;
    diag_pkg::control_s sounder_ctrl;
    logic [23:0] prescale_count;
    logic tick;
    logic lamp_raw;
    logic sounder_raw;

    // Read value of one register; bits above the fields always read as zero.
    // Shared by the read path and the read-back checks, so both see one decode.
    function automatic logic [7:0] stored_bits(input diag_pkg::control_s c);
        return 8'(c) & 8'((1 << diag_pkg::field_width) - 1);
    endfunction : stored_bits

    // Address decode for the two ports; other addresses are not claimed.
    wire lamp_sel = (io_addr == diag_pkg::lamp_reg_addr);
    wire sounder_sel = (io_addr == diag_pkg::sounder_reg_addr);
    wire [7:0] wmask = 8'((1 << diag_pkg::field_width) - 1);
    wire [7:0] next_rdata = lamp_sel ? stored_bits(lamp_ctrl) :
                            sounder_sel ? stored_bits(sounder_ctrl) : 8'h00;
    wire last_count = (prescale_count == 24'(prescale - 1));

    // Register writes; unused upper bits are not stored and read as zero.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lamp_ctrl <= diag_pkg::lamp_reset;
            sounder_ctrl <= diag_pkg::sounder_reset;
        end else begin
            if (io_write && lamp_sel) begin
                lamp_ctrl <= io_wdata & wmask;
            end
            if (io_write && sounder_sel) begin
                sounder_ctrl <= io_wdata & wmask;
            end
        end
    end

    // Read data is registered, so it appears the cycle after the read strobe.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
        end else begin
            io_rdata <= io_read ? next_rdata : 8'h00;
            io_hit <= (io_read || io_write) && (lamp_sel || sounder_sel);
        end
    end

    // Shared prescaler produces a one-cycle tick per millisecond.
    // One counter serves both generators, which keeps their ticks in step.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prescale_count <= 24'h000000;
            tick <= 1'b0;
        end else begin
            prescale_count <= last_count ? 24'h000000 : prescale_count + 24'h000001;
            tick <= last_count;
        end
    end

    // Lamp blinks: fast, normal and short.
    pattern_gen #(
        .period_a(diag_pkg::fast_period_ms),
        .on_a(diag_pkg::fast_on_ms),
        .period_b(diag_pkg::normal_period_ms),
        .on_b(diag_pkg::normal_on_ms),
        .period_c(diag_pkg::short_period_ms),
        .on_c(diag_pkg::short_on_ms)
    ) lamp_gen (
        .clock(clock),
        .resetn(resetn),
        .tick(tick),
        .ctrl(lamp_ctrl),
        .out(lamp_raw)
    );

    // Sounder beeps: short, normal and long, mapped onto the same generator.
    pattern_gen #(
        .period_a(diag_pkg::short_period_ms),
        .on_a(diag_pkg::short_on_ms),
        .period_b(diag_pkg::normal_period_ms),
        .on_b(diag_pkg::normal_on_ms),
        .period_c(diag_pkg::long_period_ms),
        .on_c(diag_pkg::long_on_ms)
    ) sounder_gen (
        .clock(clock),
        .resetn(resetn),
        .tick(tick),
        .ctrl(sounder_ctrl),
        .out(sounder_raw)
    );

    // Outputs straight from flip-flops; one extra stage of latency.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lamp <= 1'b0;
            sounder <= 1'b0;
        end else begin
            lamp <= lamp_raw;
            sounder <= sounder_raw;
        end
    end

    // Register writes land whole in the next cycle, with the unused bits cleared.
    a_lamp_write : assert property (@(posedge clock) disable iff (!resetn)
        io_write && lamp_sel |=> 8'(lamp_ctrl) == ($past(io_wdata) & wmask))
        else $error("lamp write lost");
    a_sounder_write : assert property (@(posedge clock) disable iff (!resetn)
        io_write && sounder_sel |=> 8'(sounder_ctrl) == ($past(io_wdata) & wmask))
        else $error("sounder write lost");

    // Without a write to its own port a register must not move; this catches a
    // decode that lets the neighbouring port or a read disturb it.
    a_lamp_hold : assert property (@(posedge clock) disable iff (!resetn)
        !(io_write && lamp_sel) |=> $stable(lamp_ctrl))
        else $error("lamp register changed without a write");
    a_sounder_hold : assert property (@(posedge clock) disable iff (!resetn)
        !(io_write && sounder_sel) |=> $stable(sounder_ctrl))
        else $error("sounder register changed without a write");
    a_unused_clear : assert property (@(posedge clock) disable iff (!resetn)
        lamp_ctrl.unused == 5'h00 && sounder_ctrl.unused == 5'h00)
        else $error("unused register bits were stored");

    // Read data and hit stand for the one cycle after the strobe and are zero otherwise.
    a_read_back : assert property (@(posedge clock) disable iff (!resetn)
        io_read && lamp_sel |=> io_rdata == stored_bits($past(lamp_ctrl)))
        else $error("lamp readback wrong");
    a_sounder_back : assert property (@(posedge clock) disable iff (!resetn)
        io_read && sounder_sel |=> io_rdata == stored_bits($past(sounder_ctrl)))
        else $error("sounder readback wrong");
    a_hit_mapped : assert property (@(posedge clock) disable iff (!resetn)
        (io_read || io_write) && (lamp_sel || sounder_sel) |=> io_hit)
        else $error("mapped access gave no hit");
    a_hit_refused : assert property (@(posedge clock) disable iff (!resetn)
        !(lamp_sel || sounder_sel) |=> !io_hit && io_rdata == 8'h00)
        else $error("unmapped port answered");
    a_rdata_idle : assert property (@(posedge clock) disable iff (!resetn)
        !io_read |=> io_rdata == 8'h00)
        else $error("read data without a read");

    // A disabled output goes dark two edges after the register says so.
    a_lamp_off : assert property (@(posedge clock) disable iff (!resetn)
        !lamp_ctrl.enable ##1 !lamp_ctrl.enable |=> !lamp)
        else $error("lamp on while off");
    a_sounder_off : assert property (@(posedge clock) disable iff (!resetn)
        !sounder_ctrl.enable ##1 !sounder_ctrl.enable |=> !sounder)
        else $error("sounder on while off");

    // Steady codes keep the output lit once the register has settled.
    a_lamp_steady : assert property (@(posedge clock) disable iff (!resetn)
        (lamp_ctrl.enable && lamp_ctrl.pattern == diag_pkg::pat_steady) [*2] |=> lamp)
        else $error("lamp not steady on");
    a_tone_steady : assert property (@(posedge clock) disable iff (!resetn)
        (sounder_ctrl.enable && sounder_ctrl.pattern == diag_pkg::pat_steady) [*2] |=> sounder)
        else $error("tone not continuous");

    // The output stage only delays each generator by one flip-flop.
    a_lamp_stage : assert property (@(posedge clock) disable iff (!resetn)
        lamp == $past(lamp_raw))
        else $error("lamp does not follow its generator");
    a_sounder_stage : assert property (@(posedge clock) disable iff (!resetn)
        sounder == $past(sounder_raw))
        else $error("sounder does not follow its generator");

    // The prescaler stays in range and its tick is a single-cycle pulse.
    a_count_range : assert property (@(posedge clock) disable iff (!resetn)
        prescale_count < 24'(prescale))
        else $error("prescaler count out of range");
    a_tick_align : assert property (@(posedge clock) disable iff (!resetn)
        tick |-> prescale_count == 24'h000000)
        else $error("tick not aligned with prescaler wrap");
    a_tick_spacing : assert property (@(posedge clock) disable iff (!resetn)
        tick |=> !tick)
        else $error("tick too close");

    // Main scenarios: a lamp write, a blink edge and the sounder coming on.
    c_lamp_write : cover property (@(posedge clock) disable iff (!resetn) io_write && lamp_sel);
    c_lamp_blink : cover property (@(posedge clock) disable iff (!resetn) $rose(lamp));
    c_sounder_on : cover property (@(posedge clock) disable iff (!resetn) $rose(sounder));
endmodule : diag_lamp_sounder_control

// ### diag_lamp_sounder_control_test.sv
// Self-checking testbench for the diagnostic lamp and sounder control block.
`timescale 1ns/1ps
`define check(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module diag_lamp_sounder_control_test;
    // A short prescale keeps every pattern period within a few thousand cycles.
    localparam int prescale = 2;
    localparam int win = diag_pkg::long_period_ms;
    localparam logic [15:0] lamp_a = diag_pkg::lamp_reg_addr;
    localparam logic [15:0] snd_a = diag_pkg::sounder_reg_addr;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_write = 1'b0;
    logic io_read = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic io_hit;
    logic lamp;
    logic sounder;
    int fails = 0;
    int checked = 0;
    int seed = 80;
    logic [7:0] notes[$];
    logic [7:0] want;

    diag_lamp_sounder_control #(.prescale(prescale)) uut (
        .clock(clock), .resetn(resetn), .io_addr(io_addr), .io_write(io_write),
        .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .lamp(lamp), .sounder(sounder));

    initial forever #10 clock = ~clock;

    // Prints the counts and the verdict, then stops the run.
    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    // One strobe cycle; mapped ports leave a note of the expected read data.
    task access(input logic [15:0] a, input logic wr, input logic [7:0] d,
                input logic [7:0] e);
        io_addr = a;
        io_write = wr;
        io_read = !wr;
        io_wdata = d;
        if (a == lamp_a || a == snd_a) notes.push_back(e);
        @(negedge clock);
    endtask : access

    task idle;
        io_write = 1'b0;
        io_read = 1'b0;
        @(negedge clock);
    endtask : idle

    // On ticks of each pattern inside one window of the longest period.
    function automatic int lamp_on(input int i);
        case (i)
            0: return win;
            1: return diag_pkg::fast_on_ms * (win / diag_pkg::fast_period_ms);
            2: return diag_pkg::normal_on_ms * (win / diag_pkg::normal_period_ms);
            default: return diag_pkg::short_on_ms * (win / diag_pkg::short_period_ms);
        endcase
    endfunction : lamp_on

    function automatic int snd_on(input int i);
        case (i)
            0: return win;
            1: return diag_pkg::short_on_ms * (win / diag_pkg::short_period_ms);
            2: return diag_pkg::normal_on_ms * (win / diag_pkg::normal_period_ms);
            default: return diag_pkg::long_on_ms * (win / diag_pkg::long_period_ms);
        endcase
    endfunction : snd_on

    // Counting over a whole window makes the result independent of the phase.
    task measure(input int len, output int l, output int s);
        l = 0;
        s = 0;
        repeat (len) begin
            @(negedge clock);
            if ($isunknown({lamp, sounder})) begin
                fails++;
                $display("unexpected at %0t: lamp or sounder level unknown", $time);
            end
            if (lamp === 1'b1) l++;
            if (sounder === 1'b1) s++;
        end
    endtask : measure

    // Every answer is matched against the oldest note; a stray hit is a mismatch.
    always @(negedge clock) begin
        if (resetn && io_hit !== 1'b0) begin
            if (notes.size() == 0) begin
                fails++;
                $display("unexpected at %0t: hit with no access pending", $time);
            end else begin
                want = notes.pop_front();
                `check(io_rdata, want)
            end
        end else if (resetn) begin
            `check(io_rdata, 8'h00)
        end
    end

    initial begin
        #1_000_000;
        fails++;
        conclude();
    end

    initial begin
        int l;
        int s;
        logic [7:0] r;
        repeat (6) @(negedge clock);
        `check({lamp, sounder}, 2'b00)
        resetn = 1'b1;
        access(lamp_a, 1'b0, 8'h00, diag_pkg::lamp_reset);
        access(snd_a, 1'b0, 8'h00, diag_pkg::sounder_reset);
        for (int k = 0; k < 8; k++) begin
            r = 8'($random(seed));
            access(lamp_a, 1'b1, {r[7:3], 3'(k)}, 8'h00);
            access(snd_a, 1'b1, {~r[7:3], 3'(7 - k)}, 8'h00);
            access(lamp_a, 1'b0, r, 8'(k));
            access(snd_a, 1'b0, r, 8'(7 - k));
        end
        // Neighbouring ports must be ignored and leave both registers alone.
        access(16'h0212, 1'b1, 8'hff, 8'h00);
        access(16'h020f, 1'b0, 8'h00, 8'h00);
        access(lamp_a, 1'b0, 8'h00, 8'h07);
        access(snd_a, 1'b0, 8'h00, 8'h00);
        // Pattern bits set but enables clear: both outputs stay off.
        access(lamp_a, 1'b1, 8'h06, 8'h00);
        access(snd_a, 1'b1, 8'h06, 8'h00);
        idle();
        repeat (4) @(negedge clock);
        measure(100, l, s);
        `check(l, 0)
        `check(s, 0)
        for (int i = 0; i < 4; i++) begin
            r = 8'({$random(seed)} % 32);
            access(lamp_a, 1'b1, {r[4:0], 2'(i), 1'b1}, 8'h00);
            access(snd_a, 1'b1, {r[4:0], 2'(i), 1'b1}, 8'h00);
            idle();
            repeat (win * prescale) @(negedge clock);
            measure(win * prescale, l, s);
            `check(l, lamp_on(i) * prescale)
            `check(s, snd_on(i) * prescale)
        end
        idle();
        `check(notes.size(), 0)
        conclude();
    end
endmodule : diag_lamp_sounder_control_test
